// ==== design/frc_top.sv ====
// Purpose: frame remaining down-counter of a full-speed host controller with AHB-Lite registers
// Assumes: mclk 125 MHz, nrst async active low, bit time derived by a prescaler
// Notes: counter, interval, frame sequence, low-speed cutoff and control words
// Notes on behaviour
// (R01) a 14-bit remaining count in bits 13..0 drops by one each bit time while nonzero.
// (R02) at zero the count loads the programmed interval at the next bit time boundary.
// (R03) whenever the count reaches zero the interval toggle is copied into bit 31.
// (R04) entering the operational state reloads the count from the interval value.
// (R05) the newly loaded interval governs frames from the next start of frame.
// (R06) the frame sequence count advances at every reload and wraps from ffff to zero.
// (R07) a low-speed transaction starts only when the count is at least the cutoff.
// (R08) reserved bits 30..14 read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module frc_top
  import frc_pkg::*;
#(
  parameter int unsigned BIT_CYC = frc_pkg::FRC_BIT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ls_request,
  output logic             ls_start,
  output logic             sof_pulse
);
  import frc_pkg::*;

  initial begin
    if (BIT_CYC < 2 || BIT_CYC > 255) begin
      $error("BIT_CYC out of range");
    end
  end

  // bus state
  frc_req_type           req_r, req_nxt;
  logic [31:0]           hrdata_r, hrdata_nxt;
  // block state
  logic [7:0]            pre_r, pre_nxt;
  logic [FRC_CNT_W-1:0]  remain_r, remain_nxt;
  logic                  rtog_r, rtog_nxt;
  logic [FRC_CNT_W-1:0]  ival_r, ival_nxt;
  logic                  itog_r, itog_nxt;
  logic [FRC_FN_W-1:0]   fnum_r, fnum_nxt;
  logic [FRC_LST_W-1:0]  lscut_r, lscut_nxt;
  frc_state_type         st_r, st_nxt;
  logic                  ls_start_r, ls_start_nxt;
  logic                  sof_r, sof_nxt;
  logic                  bit_tick;
  logic                  wr_en;
  logic                  enter_oper;
  logic                  reload;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ---------------- bus slave: zero wait states, always OKAY
  always_comb begin
    req_nxt = req_r;
    if (hready) begin
      req_nxt.sel   = hsel && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
      req_nxt.write = hwrite;
      req_nxt.addr  = haddr[7:0];
    end
  end

  assign wr_en = req_r.sel && req_r.write;

  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    if (hready && hsel && (htrans == HTRANS_NONSEQ) && !hwrite) begin
      unique case (haddr[7:0])
        FRC_OFS_REMAIN:   hrdata_nxt = {rtog_r, 17'h0_0000, remain_r};  // see (R08)
        FRC_OFS_INTERVAL: hrdata_nxt = {itog_r, 17'h0_0000, ival_r};
        FRC_OFS_NUMBER:   hrdata_nxt = {16'h0000, fnum_r};
        FRC_OFS_LSCUT:    hrdata_nxt = {21'h00_0000, lscut_r};
        FRC_OFS_CTRL:     hrdata_nxt = {31'h0000_0000, st_r == FRC_ST_OPER};
        default:          hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ---------------- state and counter
  always_comb begin
    pre_nxt  = (pre_r == 8'(BIT_CYC - 1)) ? 8'h00 : pre_r + 8'h01;
  end
  assign bit_tick = (pre_r == 8'(BIT_CYC - 1));

  always_comb begin
    st_nxt = st_r;
    if (wr_en && hit(req_r.addr, FRC_OFS_CTRL)) begin
      st_nxt = hwdata[0] ? FRC_ST_OPER : FRC_ST_HALT;
    end
  end
  assign enter_oper = (st_r != FRC_ST_OPER) && (st_nxt == FRC_ST_OPER);
  assign reload     = enter_oper || (st_r == FRC_ST_OPER && bit_tick && remain_r == '0);

  always_comb begin
    ival_nxt  = ival_r;
    itog_nxt  = itog_r;
    lscut_nxt = lscut_r;
    if (wr_en && hit(req_r.addr, FRC_OFS_INTERVAL)) begin
      ival_nxt = hwdata[FRC_CNT_W-1:0];
      itog_nxt = hwdata[FRC_TOGGLE_BIT];
    end
    if (wr_en && hit(req_r.addr, FRC_OFS_LSCUT)) begin
      lscut_nxt = hwdata[FRC_LST_W-1:0];
    end
  end

  always_comb begin
    remain_nxt = remain_r;
    rtog_nxt   = rtog_r;
    fnum_nxt   = fnum_r;
    sof_nxt    = 1'b0;
    if (wr_en && hit(req_r.addr, FRC_OFS_REMAIN)) begin
      remain_nxt = hwdata[FRC_CNT_W-1:0];               // see (R08)
      rtog_nxt   = hwdata[FRC_TOGGLE_BIT];
    end
    if (reload) begin
      // the interval seen now, including one written this cycle, starts the frame
      remain_nxt = ival_nxt;                            // see (R02) see (R04) see (R05)
      fnum_nxt   = fnum_r + 16'h0001;                   // see (R06)
      sof_nxt    = 1'b1;
      if (!enter_oper) begin
        rtog_nxt = itog_r;                              // see (R03)
      end
    end else if (st_r == FRC_ST_OPER && bit_tick && remain_r != '0) begin
      remain_nxt = remain_r - 14'h0001;                 // see (R01)
    end
  end

  always_comb begin
    // a request that fails the cutoff is dropped; the requester retries later
    ls_start_nxt = ls_request && (st_r == FRC_ST_OPER) &&
                   (remain_r >= {3'h0, lscut_r});       // see (R07)
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      req_r      <= '0;
      hrdata_r   <= 32'h0000_0000;
      pre_r      <= 8'h00;
      remain_r   <= 14'h0000;
      rtog_r     <= 1'b0;
      ival_r     <= FRC_INTERVAL_RST;
      itog_r     <= 1'b0;
      fnum_r     <= 16'h0000;
      lscut_r    <= FRC_LSCUT_RST;
      st_r       <= FRC_ST_HALT;
      ls_start_r <= 1'b0;
      sof_r      <= 1'b0;
    end else begin
      req_r      <= req_nxt;
      hrdata_r   <= hrdata_nxt;
      pre_r      <= pre_nxt;
      remain_r   <= remain_nxt;
      rtog_r     <= rtog_nxt;
      ival_r     <= ival_nxt;
      itog_r     <= itog_nxt;
      fnum_r     <= fnum_nxt;
      lscut_r    <= lscut_nxt;
      st_r       <= st_nxt;
      ls_start_r <= ls_start_nxt;
      sof_r      <= sof_nxt;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ls_start  = ls_start_r;
  assign sof_pulse = sof_r;

  // ---------------- assertions
  sequence s_tick_zero;
    st_r == FRC_ST_OPER && bit_tick && remain_r == '0 && !wr_en;
  endsequence

  a_count_dec: assert property (@(posedge mclk) disable iff (!nrst) // see (R01)
    st_r == FRC_ST_OPER && st_nxt == FRC_ST_OPER && bit_tick && remain_r != '0 && !wr_en
    |=> remain_r == $past(remain_r) - 14'h0001)
    else $error("count did not decrement");
  a_count_hold: assert property (@(posedge mclk) disable iff (!nrst) // see (R01)
    !bit_tick && !wr_en && !enter_oper |=> remain_r == $past(remain_r))
    else $error("count moved without a bit time");
  a_zero_reload: assert property (@(posedge mclk) disable iff (!nrst) // see (R02)
    s_tick_zero |=> remain_r == $past(ival_r) && sof_pulse)
    else $error("no reload at zero");
  a_toggle_copy: assert property (@(posedge mclk) disable iff (!nrst) // see (R03)
    s_tick_zero |=> rtog_r == $past(itog_r))
    else $error("toggle not copied");
  a_oper_reload: assert property (@(posedge mclk) disable iff (!nrst) // see (R04)
    enter_oper |=> remain_r == ival_r && st_r == FRC_ST_OPER)
    else $error("no reload on entering operation");
  a_new_frame: assert property (@(posedge mclk) disable iff (!nrst) // see (R05)
    enter_oper |=> sof_pulse ##1 !sof_pulse)
    else $error("frame not started after entry");
  a_fnum_step: assert property (@(posedge mclk) disable iff (!nrst) // see (R06)
    reload |=> fnum_r == $past(fnum_r) + 16'h0001)
    else $error("frame sequence count not advanced");
  a_ls_gate: assert property (@(posedge mclk) disable iff (!nrst) // see (R07)
    ls_start |-> $past(remain_r) >= {3'h0, $past(lscut_r)} && $past(ls_request))
    else $error("low-speed start below cutoff");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst) // see (R08)
    $past(hready && hsel && htrans == HTRANS_NONSEQ && !hwrite && haddr[7:0] == FRC_OFS_REMAIN)
    |-> hrdata[30:14] == 17'h0_0000)
    else $error("reserved bits not zero");
endmodule
`default_nettype wire

// ==== design/frc_pkg.sv ====
// Purpose: shared constants and types for the frame remaining counter
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   register offsets other than the counter itself are local choices
package frc_pkg;
  localparam int unsigned FRC_CNT_W      = 14;
  localparam int unsigned FRC_FN_W       = 16;
  localparam int unsigned FRC_LST_W      = 11;
  localparam int unsigned FRC_TOGGLE_BIT = 31;
  // byte offsets of the register words
  localparam logic [7:0] FRC_OFS_REMAIN   = 8'h00;
  localparam logic [7:0] FRC_OFS_INTERVAL = 8'h04;
  localparam logic [7:0] FRC_OFS_NUMBER   = 8'h08;
  localparam logic [7:0] FRC_OFS_LSCUT    = 8'h0c;
  localparam logic [7:0] FRC_OFS_CTRL     = 8'h10;
  // reset values
  localparam logic [13:0] FRC_INTERVAL_RST = 14'h2edf;
  localparam logic [10:0] FRC_LSCUT_RST    = 11'h628;
  // bit time: 12 MHz full-speed bit rate against the 125 MHz clock
  localparam int unsigned FRC_CLK_KHZ      = 125000;
  localparam int unsigned FRC_BIT_KHZ      = 12000;
  localparam int unsigned FRC_BIT_CYC      = FRC_CLK_KHZ / FRC_BIT_KHZ;
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } frc_req_type;

  typedef enum logic [1:0] {
    FRC_ST_HALT = 2'b00,
    FRC_ST_OPER = 2'b01
  } frc_state_type;
endpackage

// ==== testbench/frc_top_test.sv ====
// Purpose: self-checking bench for the frame remaining counter
// Assumes: zero-wait AHB-Lite slave, short prescaler for quick frames
// Notes:   frame number wrap is too long to reach here and is left untested
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module frc_top_test;
  import frc_pkg::*;
  localparam int unsigned BC = 4;
  typedef struct packed { logic [7:0] a; logic [31:0] d; } frc_row_type;
  logic        mclk, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic        ls_request, ls_start, sof_pulse;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_mismatch, total_checks, cyc, n;
  frc_row_type rows [0:5] = '{'{FRC_OFS_REMAIN, 32'h0}, '{FRC_OFS_INTERVAL, {18'h0, FRC_INTERVAL_RST}},
    '{FRC_OFS_NUMBER, 32'h0}, '{FRC_OFS_LSCUT, {21'h0, FRC_LSCUT_RST}}, '{FRC_OFS_CTRL, 32'h0},
    '{8'h20, 32'h0}};
  assign hready = hreadyout;
  frc_top #(.BIT_CYC(BC)) dut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ls_request(ls_request), .ls_start(ls_start),
    .sof_pulse(sof_pulse));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task test_done;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  // called just after a rising edge; read data is taken at the closing edge
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task do_reset;
    nrst <= 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
  endtask
  // counts edges until a frame start pulse is seen, bounded
  task wait_sof(output int k);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (sof_pulse !== 1'b1 && k < 1000);
  endtask
  initial begin
    nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; ls_request = 1'b0;
    n_mismatch = 0; total_checks = 0; cyc = 0;
    @(posedge mclk);
    do_reset;
    foreach (rows[i]) begin
      ahb(1'b0, rows[i].a, 32'h0, rd);
      `CHK("reset read", rows[i].d, rd)
    end
    // halted, so the count holds what was written; reserved bits must drop
    ahb(1'b1, FRC_OFS_REMAIN, 32'h7fffffff, rd);
    ahb(1'b0, FRC_OFS_REMAIN, 32'h0, rd);
    `CHK("reserved bits", 32'h00003fff, rd)
    ahb(1'b1, FRC_OFS_INTERVAL, 32'h80000005, rd);
    ahb(1'b1, FRC_OFS_LSCUT, 32'h0, rd);
    ahb(1'b1, FRC_OFS_CTRL, 32'h1, rd);
    ahb(1'b0, FRC_OFS_REMAIN, 32'h0, rd);
    `CHK("entry reload", 1'b1, rd[13:0] <= 14'h5 && rd[13:0] != 14'h0)
    `CHK("entry toggle", 1'b0, rd[31])
    wait_sof(n);
    wait_sof(n);
    `CHK("frame period", 6 * BC, n)
    ahb(1'b0, FRC_OFS_REMAIN, 32'h0, rd);
    `CHK("copied toggle", 1'b1, rd[31])
    `CHK("remaining zero gap", 15'h0, rd[30:16])
    ahb(1'b0, FRC_OFS_NUMBER, 32'h0, rd);
    `CHK("frame number", 32'h3, rd)
    // cutoff 0 always admits, 7ff is above any count of a 6-bit-time frame
    for (int j = 0; j < 2; j++) begin
      ahb(1'b1, FRC_OFS_LSCUT, (j == 0) ? 32'h0 : 32'h7ff, rd);
      ls_request <= 1'b1;
      @(posedge mclk);
      ls_request <= 1'b0;
      @(posedge mclk);
      `CHK("ls start", (j == 0) ? 1'b1 : 1'b0, ls_start)
    end
    do_reset;
    ahb(1'b0, FRC_OFS_NUMBER, 32'h0, rd);
    `CHK("number after reset", 32'h0, rd)
    ahb(1'b0, FRC_OFS_REMAIN, 32'h0, rd);
    `CHK("count after reset", 32'h0, rd)
    test_done;
  end
endmodule
`default_nettype wire
